// ### ckc_consts.svh
// Constants for the clock source and PLL controller
`ifndef CKC_CONSTS_SVH
`define CKC_CONSTS_SVH

`define CKC_CLK_NS 50
`define CKC_GATE_NS 200
`define CKC_GATE_CYC ((`CKC_GATE_NS + `CKC_CLK_NS - 1) / `CKC_CLK_NS)
`define CKC_CNT_W 3

`define CKC_N_W 8
`define CKC_M_W 15
`define CKC_N_MAX 256
`define CKC_M_MAX 32768

`define CKC_CPU_DIV_W 8
`define CKC_USB_DIV_W 4
`define CKC_CPU_DIV_RST 8'h00
`define CKC_USB_DIV_RST 4'h0
`define CKC_PCLK_W 2
`define CKC_PCLK_RST 2'h0
`define CKC_NUM_PERIPH 8

`endif

// ### ckc_pkg.sv
// Types shared by the clock source and PLL controller
package ckc_pkg;
  `include "ckc_consts.svh"

  typedef enum logic [1:0] {
    SRC_IRC = 2'h0,
    SRC_MAIN = 2'h1,
    SRC_RTC = 2'h2
  } ckc_src_t;

  typedef enum logic [1:0] {
    WDT_IRC = 2'h0,
    WDT_RTC = 2'h1,
    WDT_APB = 2'h2
  } ckc_wdt_src_t;

  typedef enum logic [2:0] {
    OUT_CPU = 3'h0,
    OUT_IRC = 3'h1,
    OUT_MAIN = 3'h2,
    OUT_RTC = 3'h3,
    OUT_USB = 3'h4
  } ckc_out_src_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_GATE = 4'h2,
    ST_SWAP = 4'h4,
    ST_RESUME = 4'h8
  } ckc_state_t;

  // Dividers are stored as value minus one
  typedef struct packed {
    logic [`CKC_N_W-1:0] n_m1;
    logic [`CKC_M_W-1:0] m_m1;
  } ckc_pll_cfg_t;

  typedef struct packed {
    logic power;
    logic connect;
    ckc_pll_cfg_t cfg;
  } ckc_pll_ctrl_t;
endpackage

// ### ckc_sync3.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module ckc_sync3
  import ckc_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic async_in,
  output logic level_out
);
  logic s1;
  logic s2;
  logic s3;
  logic level;
  logic next_level;

  always_comb
  begin
    next_level = level;
    if (s2 == s3)
    begin
      next_level = s3;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end

  assign level_out = level;
endmodule

// ### ckc_pclk_slot.sv
// One peripheral clock select slot
`timescale 1ns/1ps
module ckc_pclk_slot
  import ckc_pkg::*;
#(
  parameter int IDX = 0,
  parameter int IDX_W = 3
)
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic wr_in,
  input wire logic [IDX_W-1:0] idx_in,
  input wire logic [`CKC_PCLK_W-1:0] sel_in,
  output logic [`CKC_PCLK_W-1:0] sel_out
);
  logic [`CKC_PCLK_W-1:0] sel;
  logic [`CKC_PCLK_W-1:0] next_sel;

  always_comb
  begin
    next_sel = sel;
    if (wr_in && (idx_in == IDX_W'(IDX)))
    begin
      next_sel = sel_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      sel <= `CKC_PCLK_RST;
    end
    else
    begin
      sel <= next_sel;
    end
  end

  assign sel_out = sel;
endmodule

// ### ckc_clock_ctrl.sv
// Clock source selection and PLL control
// Notes on behaviour
// - Reset selects internal RC oscillator as source
// - Software picks any of three oscillators
// - Pre-divider N ranges 1 to 256
// - Feedback divider M ranges 1 to 32768
// - Reset and power-down turn PLL off, bypassed
// - Configure, enable, await lock, then connect
// - CPU clock equals input unless PLL connected
// - USB PLL fed by main oscillator only
// - USB PLL off at reset; main PLL feeds USB
// - USB PLL output has even duty cycle
// - Watchdog clock from RC, RTC or APB
// - Each peripheral clock chosen independently
// - Clock output routes one of five clocks
// - RTC oscillator may drive PLL and CPU
// - Main oscillator usable with or without PLL
// - Deep-sleep disconnects PLL, clears CPU and USB dividers
`timescale 1ns/1ps
module ckc_clock_ctrl
  import ckc_pkg::*;
#(
  parameter int NUM_PERIPH = `CKC_NUM_PERIPH,
  parameter int IDX_W = 3
)
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic src_sel_wr_in,
  input wire ckc_src_t src_sel_in,
  input wire logic pll_cfg_wr_in,
  input wire ckc_pll_cfg_t pll_cfg_in,
  input wire logic pll_enable_wr_in,
  input wire logic pll_enable_in,
  input wire logic pll_connect_wr_in,
  input wire logic pll_connect_in,
  input wire logic main_pll_lock_in,
  input wire logic usb_pll_enable_wr_in,
  input wire logic usb_pll_enable_in,
  input wire logic usb_pll_lock_in,
  input wire logic div_wr_in,
  input wire logic [`CKC_CPU_DIV_W-1:0] cpu_div_in,
  input wire logic [`CKC_USB_DIV_W-1:0] usb_div_in,
  input wire logic wdt_sel_wr_in,
  input wire ckc_wdt_src_t wdt_sel_in,
  input wire logic pclk_wr_in,
  input wire logic [IDX_W-1:0] pclk_idx_in,
  input wire logic [`CKC_PCLK_W-1:0] pclk_sel_in,
  input wire logic clkout_sel_wr_in,
  input wire ckc_out_src_t clkout_sel_in,
  input wire logic power_down_entry_in,
  input wire logic deep_sleep_entry_in,
  output ckc_src_t pll_src_sel_out,
  output ckc_pll_ctrl_t main_pll_ctrl_out,
  output logic main_pll_locked_out,
  output logic cpu_clk_gate_out,
  output logic cpu_switch_busy_out,
  output logic [`CKC_CPU_DIV_W-1:0] cpu_div_out,
  output logic [`CKC_USB_DIV_W-1:0] usb_div_out,
  output logic usb_pll_power_out,
  output logic usb_clk_from_usb_pll_out,
  output logic usb_clk_gate_out,
  output ckc_wdt_src_t wdt_sel_out,
  output logic [NUM_PERIPH*`CKC_PCLK_W-1:0] pclk_sel_out,
  output ckc_out_src_t clkout_sel_out
);
  localparam logic [`CKC_CNT_W-1:0] GATE_LAST = `CKC_CNT_W'(`CKC_GATE_CYC - 1);

  logic main_lock_sync;
  logic usb_lock_sync;
  logic force_off;

  // Configuration group
  logic pll_power;
  logic next_pll_power;
  ckc_pll_cfg_t pll_cfg;
  ckc_pll_cfg_t next_pll_cfg;
  logic usb_power;
  logic next_usb_power;
  logic usb_locked;
  logic next_usb_locked;
  logic [`CKC_CPU_DIV_W-1:0] cpu_div;
  logic [`CKC_CPU_DIV_W-1:0] next_cpu_div;
  logic [`CKC_USB_DIV_W-1:0] usb_div;
  logic [`CKC_USB_DIV_W-1:0] next_usb_div;
  ckc_wdt_src_t wdt_sel;
  ckc_wdt_src_t next_wdt_sel;
  ckc_out_src_t clkout_sel;
  ckc_out_src_t next_clkout_sel;

  // Switch group
  ckc_state_t state;
  ckc_state_t next_state;
  logic [`CKC_CNT_W-1:0] cnt;
  logic [`CKC_CNT_W-1:0] next_cnt;
  logic gate;
  logic next_gate;
  ckc_src_t src;
  ckc_src_t next_src;
  ckc_src_t pend_src;
  ckc_src_t next_pend_src;
  logic conn;
  logic next_conn;
  logic pend_conn;
  logic next_pend_conn;

  // Lock indicators come from the analog PLLs, so they cross into this domain
  ckc_sync3 u_main_lock (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .async_in(main_pll_lock_in),
    .level_out(main_lock_sync)
  );

  ckc_sync3 u_usb_lock (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .async_in(usb_pll_lock_in),
    .level_out(usb_lock_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi++)
    begin : g_pclk
      ckc_pclk_slot #(.IDX(gi), .IDX_W(IDX_W)) u_slot (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .wr_in(pclk_wr_in),
        .idx_in(pclk_idx_in),
        .sel_in(pclk_sel_in),
        .sel_out(pclk_sel_out[gi*`CKC_PCLK_W +: `CKC_PCLK_W])
      );
    end
  endgenerate

  // Power-down does everything deep-sleep does
  assign force_off = power_down_entry_in | deep_sleep_entry_in;

  always_comb
  begin
    next_pll_power = pll_power;
    next_pll_cfg = pll_cfg;
    next_usb_power = usb_power;
    next_usb_locked = usb_power & usb_lock_sync;
    next_cpu_div = cpu_div;
    next_usb_div = usb_div;
    next_wdt_sel = wdt_sel;
    next_clkout_sel = clkout_sel;
    // Dividers are only taken while the PLL is off, so lock is never chased
    if (pll_cfg_wr_in && !pll_power)
    begin
      next_pll_cfg = pll_cfg_in;
    end
    if (pll_enable_wr_in)
    begin
      // Disabling is refused while connected or about to connect
      if (pll_enable_in || (!conn && !pend_conn))
      begin
        next_pll_power = pll_enable_in;
      end
    end
    if (usb_pll_enable_wr_in)
    begin
      next_usb_power = usb_pll_enable_in;
      next_usb_locked = 1'b0;
    end
    if (div_wr_in)
    begin
      next_cpu_div = cpu_div_in;
      next_usb_div = usb_div_in;
    end
    if (wdt_sel_wr_in)
    begin
      next_wdt_sel = wdt_sel_in;
    end
    if (clkout_sel_wr_in)
    begin
      next_clkout_sel = clkout_sel_in;
    end
    if (force_off)
    begin
      next_pll_power = 1'b0;
      next_cpu_div = `CKC_CPU_DIV_RST;
      next_usb_div = `CKC_USB_DIV_RST;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pll_power <= 1'b0;
      pll_cfg <= '0;
      usb_power <= 1'b0;
      usb_locked <= 1'b0;
      cpu_div <= `CKC_CPU_DIV_RST;
      usb_div <= `CKC_USB_DIV_RST;
      wdt_sel <= WDT_IRC;
      clkout_sel <= OUT_CPU;
    end
    else
    begin
      pll_power <= next_pll_power;
      pll_cfg <= next_pll_cfg;
      usb_power <= next_usb_power;
      usb_locked <= next_usb_locked;
      cpu_div <= next_cpu_div;
      usb_div <= next_usb_div;
      wdt_sel <= next_wdt_sel;
      clkout_sel <= next_clkout_sel;
    end
  end

  // Source or connection changes stop the CPU clock, swap, then restart it
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_gate = gate;
    next_src = src;
    next_conn = conn;
    next_pend_src = pend_src;
    next_pend_conn = pend_conn;
    if (src_sel_wr_in)
    begin
      next_pend_src = src_sel_in;
    end
    if (pll_connect_wr_in)
    begin
      next_pend_conn = pll_connect_in & pll_power & main_lock_sync;
    end
    // Lost lock falls back to bypass; the PLL clock runs a few cycles more
    if (!main_lock_sync)
    begin
      next_pend_conn = 1'b0;
    end
    case (state)
      ST_IDLE:
      begin
        if ((pend_src != src) || (pend_conn != conn))
        begin
          next_state = ST_GATE;
          next_gate = 1'b0;
          next_cnt = '0;
        end
      end
      ST_GATE:
      begin
        next_cnt = cnt + `CKC_CNT_W'(1);
        if (cnt == GATE_LAST)
        begin
          next_state = ST_SWAP;
        end
      end
      ST_SWAP:
      begin
        next_src = pend_src;
        next_conn = pend_conn & pll_power;
        next_cnt = '0;
        next_state = ST_RESUME;
      end
      ST_RESUME:
      begin
        next_cnt = cnt + `CKC_CNT_W'(1);
        if (cnt == GATE_LAST)
        begin
          next_state = ST_IDLE;
          next_gate = 1'b1;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_gate = 1'b1;
        next_cnt = '0;
      end
    endcase
    // Clocks stop in these modes anyway, so no gating sequence is needed
    if (force_off)
    begin
      next_conn = 1'b0;
      next_pend_conn = 1'b0;
      next_state = ST_IDLE;
      next_gate = 1'b1;
      next_cnt = '0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      gate <= 1'b1;
      src <= SRC_IRC;
      pend_src <= SRC_IRC;
      conn <= 1'b0;
      pend_conn <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      gate <= next_gate;
      src <= next_src;
      pend_src <= next_pend_src;
      conn <= next_conn;
      pend_conn <= next_pend_conn;
    end
  end

  assign pll_src_sel_out = src;
  assign main_pll_ctrl_out = '{power: pll_power, connect: conn, cfg: pll_cfg};
  assign main_pll_locked_out = pll_power & main_lock_sync;
  assign cpu_clk_gate_out = gate;
  assign cpu_switch_busy_out = (state != ST_IDLE);
  assign cpu_div_out = cpu_div;
  assign usb_div_out = usb_div;
  assign usb_pll_power_out = usb_power;
  // Only the locked USB PLL output is used, which is the even-duty one
  assign usb_clk_from_usb_pll_out = usb_power;
  assign usb_clk_gate_out = ~usb_power | usb_locked;
  assign wdt_sel_out = wdt_sel;
  assign clkout_sel_out = clkout_sel;

  property p_reset_state;
    @(posedge clk_in) $past(srst_in) |-> (src == SRC_IRC) && !pll_power && !conn;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_cfg_store;
    @(posedge clk_in) disable iff (srst_in)
      pll_cfg_wr_in && !pll_power |=> (pll_cfg == $past(pll_cfg_in));
  endproperty
  a_cfg_store: assert property (p_cfg_store) else $error("pll config not stored");

  property p_cfg_frozen;
    @(posedge clk_in) disable iff (srst_in) pll_power |=> $stable(pll_cfg);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("config changed while on");

  property p_no_conn_unlocked;
    @(posedge clk_in) disable iff (srst_in)
      pll_connect_wr_in && !(pll_power && main_lock_sync) |=> !pend_conn;
  endproperty
  a_no_conn_unlocked: assert property (p_no_conn_unlocked) else $error("connect taken");

  property p_bypass_when_off;
    @(posedge clk_in) disable iff (srst_in) !pll_power |-> !conn;
  endproperty
  a_bypass_when_off: assert property (p_bypass_when_off) else $error("connected while off");

  property p_gate_low_span;
    @(posedge clk_in) disable iff (srst_in || force_off) $fell(gate) |-> !gate [*8];
  endproperty
  a_gate_low_span: assert property (p_gate_low_span) else $error("gate reopened early");

  property p_swap_gated;
    @(posedge clk_in) disable iff (srst_in || force_off)
      (state == ST_SWAP) |=> !gate [*4] ##1 gate;
  endproperty
  a_swap_gated: assert property (p_swap_gated) else $error("swap timing wrong");

  property p_sleep_clear;
    @(posedge clk_in) disable iff (srst_in) deep_sleep_entry_in |=>
      (cpu_div == `CKC_CPU_DIV_RST) && (usb_div == `CKC_USB_DIV_RST) && !pll_power && !conn;
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("deep-sleep not applied");

  property p_usb_gated;
    @(posedge clk_in) disable iff (srst_in) $rose(usb_power) |-> !usb_clk_gate_out;
  endproperty
  a_usb_gated: assert property (p_usb_gated) else $error("usb clock not gated");

  property p_usb_off_reset;
    @(posedge clk_in) $past(srst_in) |-> !usb_clk_from_usb_pll_out && usb_clk_gate_out;
  endproperty
  a_usb_off_reset: assert property (p_usb_off_reset) else $error("usb pll on after reset");
endmodule

// ### ckc_pll_model.sv
// Behavioural model of the main and USB PLL lock detectors
`timescale 1ns/1ps
module ckc_pll_model
  import ckc_pkg::*;
#(
  parameter int LOCK_CYC = 6
)
(
  input wire logic clk_in,
  input wire logic main_power_in,
  input wire logic usb_power_in,
  input wire logic drop_in,
  output logic main_lock_out,
  output logic usb_lock_out
);
  int main_cnt = 0;
  int usb_cnt = 0;
  // Settle counts restart whenever a PLL is powered off
  always @(posedge clk_in)
  begin
    main_cnt <= main_power_in ? main_cnt + 1 : 0;
    usb_cnt <= usb_power_in ? usb_cnt + 1 : 0;
  end
  // Inputs are taken as legal, so lock always follows the settle time; drop_in forces a loss of main lock only
  assign main_lock_out = main_power_in && !drop_in && main_cnt >= LOCK_CYC;
  assign usb_lock_out = usb_power_in && usb_cnt >= LOCK_CYC;
endmodule

// ### tb_top.sv
// Self-checking testbench for the clock source and PLL controller
`timescale 1ns/1ps
module tb_top
  import ckc_pkg::*;
;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [10:0] wr = '0;
  ckc_src_t src_sel_in = SRC_IRC;
  ckc_pll_cfg_t pll_cfg_in = '0;
  logic pll_enable_in = 1'b0;
  logic pll_connect_in = 1'b0;
  logic usb_pll_enable_in = 1'b0;
  logic [7:0] cpu_div_in = 8'h00;
  logic [3:0] usb_div_in = 4'h0;
  ckc_wdt_src_t wdt_sel_in = WDT_IRC;
  logic [2:0] pclk_idx_in = 3'h0;
  logic [1:0] pclk_sel_in = 2'h0;
  ckc_out_src_t clkout_sel_in = OUT_CPU;
  logic drop = 1'b0;
  logic main_lock, usb_lock, main_pll_locked_out, cpu_clk_gate_out, cpu_switch_busy_out;
  logic usb_pll_power_out, usb_clk_from_usb_pll_out, usb_clk_gate_out;
  logic [7:0] cpu_div_out;
  logic [3:0] usb_div_out;
  logic [15:0] pclk_sel_out;
  ckc_src_t pll_src_sel_out;
  ckc_pll_ctrl_t ctl;
  ckc_wdt_src_t wdt_sel_out;
  ckc_out_src_t clkout_sel_out;
  int bad_count = 0;
  int check_count = 0;

  always #25 clk_in = ~clk_in;

  ckc_clock_ctrl dut_u (.clk_in, .srst_in, .src_sel_wr_in(wr[0]), .src_sel_in,
    .pll_cfg_wr_in(wr[1]), .pll_cfg_in, .pll_enable_wr_in(wr[2]), .pll_enable_in,
    .pll_connect_wr_in(wr[3]), .pll_connect_in, .main_pll_lock_in(main_lock),
    .usb_pll_enable_wr_in(wr[4]), .usb_pll_enable_in, .usb_pll_lock_in(usb_lock),
    .div_wr_in(wr[5]), .cpu_div_in, .usb_div_in, .wdt_sel_wr_in(wr[6]), .wdt_sel_in,
    .pclk_wr_in(wr[7]), .pclk_idx_in, .pclk_sel_in, .clkout_sel_wr_in(wr[8]), .clkout_sel_in,
    .power_down_entry_in(wr[9]), .deep_sleep_entry_in(wr[10]), .pll_src_sel_out,
    .main_pll_ctrl_out(ctl), .main_pll_locked_out, .cpu_clk_gate_out, .cpu_switch_busy_out,
    .cpu_div_out, .usb_div_out, .usb_pll_power_out, .usb_clk_from_usb_pll_out,
    .usb_clk_gate_out, .wdt_sel_out, .pclk_sel_out, .clkout_sel_out);

  ckc_pll_model pll_u (.clk_in, .main_power_in(ctl.power), .usb_power_in(usb_pll_power_out),
    .drop_in(drop), .main_lock_out(main_lock), .usb_lock_out(usb_lock));

  task complete_run();
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", nm, e, g);
      bad_count++;
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Strobes last exactly one edge; outputs are sampled 1 ns after it
  task strobe(input int k);
    @(posedge clk_in);
    wr[k] <= 1'b1;
    @(posedge clk_in);
    wr[k] <= 1'b0;
    #1;
  endtask

  function logic pick(input int s);
    case (s)
      0: return cpu_switch_busy_out;
      1: return main_pll_locked_out;
      2: return usb_clk_gate_out;
      default: return ctl.connect;
    endcase
  endfunction

  task wait_bit(input int s, input logic v);
    int i;
    for (i = 0; i < 60 && pick(s) !== v; i++)
      cyc(1);
    if (i == 60)
    begin
      $display("BAD wait %0d exp %b got %b", s, v, pick(s));
      bad_count++;
      complete_run();
    end
  endtask

  task gate_seq(input int k);
    int lo;
    lo = 0;
    strobe(k);
    for (int i = 0; i < 30; i++)
    begin
      cyc(1);
      if (cpu_clk_gate_out === 1'b0)
        lo++;
      else if (lo > 0)
        break;
    end
    // A gate that never fell or never reopened used up the bound
    if (lo == 0 || cpu_clk_gate_out !== 1'b1)
    begin
      $display("BAD gate_seq exp 1 got %b", cpu_clk_gate_out);
      bad_count++;
      complete_run();
    end
    chk("gate_low", 9, lo);
    chk("busy", 0, cpu_switch_busy_out);
  endtask

  task t_reset();
    chk("src", SRC_IRC, pll_src_sel_out);
    chk("ctl", 0, ctl);
    chk("usb_pwr", 0, usb_pll_power_out);
    chk("usb_gate", 1, usb_clk_gate_out);
    chk("gate", 1, cpu_clk_gate_out);
    chk("sel", {wdt_sel_out, clkout_sel_out, pclk_sel_out}, {WDT_IRC, OUT_CPU, 16'h0000});
  endtask

  task t_sources();
    ckc_src_t s[3];
    s = '{SRC_MAIN, SRC_RTC, SRC_IRC};
    foreach (s[i])
    begin
      src_sel_in <= s[i];
      gate_seq(0);
      chk("src", s[i], pll_src_sel_out);
    end
  endtask

  task t_pll();
    pll_cfg_in <= '{n_m1: 8'hff, m_m1: 15'h7fff};
    strobe(1);
    chk("cfg", 23'h7fffff, ctl.cfg);
    pll_connect_in <= 1'b1;
    strobe(3);
    cyc(12);
    chk("early_conn", 0, ctl.connect);
    pll_enable_in <= 1'b1;
    strobe(2);
    chk("power", 1, ctl.power);
    chk("locked", 0, main_pll_locked_out);
    strobe(3);
    cyc(1);
    chk("unlk_busy", 0, cpu_switch_busy_out);
    pll_cfg_in <= '0;
    strobe(1);
    chk("cfg_held", 23'h7fffff, ctl.cfg);
    wait_bit(1, 1'b1);
    gate_seq(3);
    chk("conn", 1, ctl.connect);
    pll_enable_in <= 1'b0;
    strobe(2);
    chk("no_off", 1, ctl.power);
    drop <= 1'b1;
    wait_bit(3, 1'b0);
    wait_bit(0, 1'b0);
    chk("locked", 0, main_pll_locked_out);
    drop <= 1'b0;
    wait_bit(1, 1'b1);
    gate_seq(3);
    cpu_div_in <= 8'ha5;
    usb_div_in <= 4'h9;
    strobe(5);
    chk("divs", 12'ha59, {cpu_div_out, usb_div_out});
    strobe(10);
    chk("ds_ctl", 2'b00, {ctl.power, ctl.connect});
    chk("ds_divs", 12'h000, {cpu_div_out, usb_div_out});
    chk("ds_gate", 1, cpu_clk_gate_out);
    pll_enable_in <= 1'b1;
    strobe(2);
    strobe(9);
    chk("pd_ctl", 2'b00, {ctl.power, ctl.connect});
    chk("pd_src", SRC_IRC, pll_src_sel_out);
  endtask

  task t_usb();
    chk("from_usb", 0, usb_clk_from_usb_pll_out);
    usb_pll_enable_in <= 1'b1;
    strobe(4);
    chk("usb_on", 2'b10, {usb_clk_from_usb_pll_out, usb_clk_gate_out});
    wait_bit(2, 1'b1);
    usb_pll_enable_in <= 1'b0;
    strobe(4);
    chk("usb_off", 3'b001, {usb_pll_power_out, usb_clk_from_usb_pll_out, usb_clk_gate_out});
  endtask

  task t_sel();
    logic [15:0] e;
    for (int i = 0; i < 3; i++)
    begin
      wdt_sel_in <= ckc_wdt_src_t'(i);
      strobe(6);
      chk("wdt", i, wdt_sel_out);
    end
    for (int i = 0; i < 5; i++)
    begin
      clkout_sel_in <= ckc_out_src_t'(i);
      strobe(8);
      chk("clkout", i, clkout_sel_out);
    end
    for (int i = 0; i < 8; i++)
    begin
      pclk_idx_in <= 3'(i);
      pclk_sel_in <= 2'(i + 1);
      e[2*i+:2] = 2'(i + 1);
      strobe(7);
    end
    chk("pclk", e, pclk_sel_out);
    pclk_idx_in <= 3'h2;
    pclk_sel_in <= 2'h0;
    e[5:4] = 2'h0;
    strobe(7);
    chk("pclk_one", e, pclk_sel_out);
  endtask

  initial
  begin
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    #1;
    t_reset();
    t_sources();
    t_pll();
    t_usb();
    t_sel();
    complete_run();
  end
endmodule
